// [sicc_irq_coalesce.sv]
// completion, delay and error interrupt coalescing with an AXI4-Lite register slave
// Contract
// - completion interrupt enable gates completion interrupts
// - completion enable sits at control bit 12
// - bit 13 delay enable, resets zero
// - delay, threshold, timer need scatter-gather present
// - bit 14 error enable, resets zero
// - bit 15 reserved, reads zero, ignores writes
// - bits 23:16 threshold, resets to one
// - counter decrements per completion, fires at zero
// - writing zero threshold leaves field unchanged
// - bits 31:24 delay timeout, resets zero
// - timer starts at packet end, stops and clears at packet start
// - one timeout unit is 125 clocks
// - zero timeout never raises delay interrupt
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "sicc_defines.svh"

module sicc_irq_coalesce #(
    parameter int ADDR_W = 8,
    parameter bit SG_PRESENT = 1'b1,
    parameter int DLY_UNIT_CYC = `SICC_DLY_UNIT_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    // write data channel
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // write response channel
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    // read data channel
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // channel events, one-cycle pulses from the data mover
    input wire logic completion_event_in,
    input wire logic error_event_in,
    input wire logic packet_start_in,
    input wire logic packet_end_in,
    // interrupt toward the host
    output logic irq_out
);

    // 0 = unmapped, 1 = control, 2 = status
    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
        logic [1:0] sel;
        sel = 2'h0;
        if (addr == ADDR_W'(`SICC_CTRL_OFS)) begin
            sel = 2'h1;
        end else if (addr == ADDR_W'(`SICC_STAT_OFS)) begin
            sel = 2'h2;
        end
        return sel;
    endfunction

    // write channel state
    sicc_pkg::sicc_bus_e wst_r, wst_nxt;
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic do_write, wr_ctrl, wr_stat;

    always_comb begin
        wst_nxt = wst_r;
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bresp_nxt = bresp_r;
        do_write = 1'b0;
        if (s_axi_awvalid_in && !aw_have_r) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !w_have_r) begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata_in;
            w_strb_nxt = s_axi_wstrb_in;
        end
        case (wst_r)
            sicc_pkg::SICC_IDLE: begin
                if (aw_have_r && w_have_r) begin
                    do_write = 1'b1;
                    aw_have_nxt = 1'b0;
                    w_have_nxt = 1'b0;
                    bresp_nxt = (reg_sel(aw_addr_r) == 2'h0) ? `SICC_RESP_SLVERR
                                                             : `SICC_RESP_OKAY;
                    wst_nxt = sicc_pkg::SICC_RESP;
                end
            end
            sicc_pkg::SICC_RESP: begin
                if (s_axi_bready_in) begin
                    wst_nxt = sicc_pkg::SICC_IDLE;
                end
            end
            default: begin
                wst_nxt = sicc_pkg::SICC_IDLE;
            end
        endcase
        wr_ctrl = do_write && reg_sel(aw_addr_r) == 2'h1;
        wr_stat = do_write && reg_sel(aw_addr_r) == 2'h2;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wst_r <= sicc_pkg::SICC_IDLE;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            bresp_r <= `SICC_RESP_OKAY;
        end else begin
            wst_r <= wst_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    assign s_axi_awready_out = !aw_have_r;
    assign s_axi_wready_out = !w_have_r;
    assign s_axi_bvalid_out = (wst_r == sicc_pkg::SICC_RESP);
    assign s_axi_bresp_out = bresp_r;

    // control, counter and pending state
    sicc_pkg::sicc_ctrl_s ctrl_r, ctrl_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [2:0] pend_r, pend_nxt;
    logic irq_r, irq_nxt;
    logic fire, dly_expire, dly_running;
    logic [7:0] new_thr;

    always_comb begin
        ctrl_nxt = ctrl_r;
        cnt_nxt = cnt_r;
        pend_nxt = pend_r;
        fire = 1'b0;
        new_thr = w_data_r[`SICC_THR_MSB:`SICC_THR_LSB];
        if (wr_ctrl) begin
            if (w_strb_r[1]) begin
                ctrl_nxt.cmp_en = w_data_r[`SICC_CMP_EN_BIT];
                ctrl_nxt.dly_en = w_data_r[`SICC_DLY_EN_BIT];
                ctrl_nxt.err_en = w_data_r[`SICC_ERR_EN_BIT];
            end
            if (w_strb_r[2] && new_thr != 8'h00) begin
                ctrl_nxt.threshold = new_thr;
                cnt_nxt = new_thr;
            end
            if (w_strb_r[3]) begin
                ctrl_nxt.timeout = w_data_r[`SICC_TMO_MSB:`SICC_TMO_LSB];
            end
        end
        // without scatter-gather every completion fires on its own
        if (completion_event_in) begin
            if (!SG_PRESENT || cnt_r <= 8'h01) begin
                fire = 1'b1;
                cnt_nxt = ctrl_nxt.threshold;
            end else begin
                cnt_nxt = cnt_r - 8'h01;
            end
        end
        // clear first so a same-cycle event still lands
        if (wr_stat && w_strb_r[0]) begin
            pend_nxt = pend_r & ~w_data_r[2:0];
        end
        if (fire && ctrl_r.cmp_en) begin
            pend_nxt[`SICC_PEND_CMP] = 1'b1;
        end
        if (dly_expire && SG_PRESENT && ctrl_r.dly_en) begin
            pend_nxt[`SICC_PEND_DLY] = 1'b1;
        end
        if (error_event_in && ctrl_r.err_en) begin
            pend_nxt[`SICC_PEND_ERR] = 1'b1;
        end
        irq_nxt = |pend_nxt;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_r <= '{timeout: `SICC_TMO_RST, threshold: `SICC_THR_RST,
                        err_en: 1'b0, dly_en: 1'b0, cmp_en: 1'b0};
            cnt_r <= `SICC_THR_RST;
            pend_r <= 3'h0;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign irq_out = irq_r;

    // timer sees a zero timeout when scatter-gather is absent, so it never expires
    sicc_delay_timer #(
        .UNIT_CYC(DLY_UNIT_CYC)
    ) u_timer (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .timeout_in(SG_PRESENT ? ctrl_r.timeout : 8'h00),
        .packet_start_in(packet_start_in),
        .packet_end_in(packet_end_in),
        .expire_out(dly_expire),
        .running_out(dly_running)
    );

    // read channel
    sicc_pkg::sicc_bus_e rst_r, rst_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    always_comb begin
        rst_nxt = rst_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        case (rst_r)
            sicc_pkg::SICC_IDLE: begin
                if (s_axi_arvalid_in) begin
                    rst_nxt = sicc_pkg::SICC_RESP;
                    rresp_nxt = `SICC_RESP_OKAY;
                    case (reg_sel(s_axi_araddr_in))
                        2'h1: rdata_nxt = {ctrl_r.timeout, ctrl_r.threshold, 1'b0,
                                           ctrl_r.err_en, ctrl_r.dly_en, ctrl_r.cmp_en,
                                           12'h000};
                        2'h2: rdata_nxt = {15'h0000, dly_running, cnt_r, 5'h00, pend_r};
                        default: begin
                            rdata_nxt = 32'h00000000;
                            rresp_nxt = `SICC_RESP_SLVERR;
                        end
                    endcase
                end
            end
            sicc_pkg::SICC_RESP: begin
                if (s_axi_rready_in) begin
                    rst_nxt = sicc_pkg::SICC_IDLE;
                end
            end
            default: begin
                rst_nxt = sicc_pkg::SICC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rst_r <= sicc_pkg::SICC_IDLE;
            rdata_r <= 32'h00000000;
            rresp_r <= `SICC_RESP_OKAY;
        end else begin
            rst_r <= rst_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign s_axi_arready_out = (rst_r == sicc_pkg::SICC_IDLE);
    assign s_axi_rvalid_out = (rst_r == sicc_pkg::SICC_RESP);
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence last_completion;
        completion_event_in && ctrl_r.cmp_en && (!SG_PRESENT || cnt_r <= 8'h01);
    endsequence

    sequence ctrl_byte_write(int lane);
        wr_ctrl && w_strb_r[lane];
    endsequence

    AST_CMP_GATE: assert property ($rose(pend_r[`SICC_PEND_CMP]) |-> $past(ctrl_r.cmp_en))
        else $error("completion pending set while disabled");
    AST_CMP_FIRE: assert property (last_completion |=> irq_out && cnt_r == ctrl_r.threshold)
        else $error("completion count end did not raise irq and reload");
    AST_CMP_DEC: assert property (completion_event_in && SG_PRESENT && cnt_r > 8'h01 && !wr_ctrl
                                  |=> cnt_r == $past(cnt_r) - 8'h01)
        else $error("completion counter did not step down");
    AST_DLY_GATE: assert property ($rose(pend_r[`SICC_PEND_DLY]) |-> $past(ctrl_r.dly_en)
                                   && SG_PRESENT)
        else $error("delay pending set while disabled");
    AST_ERR_GATE: assert property (error_event_in && ctrl_r.err_en |=> pend_r[`SICC_PEND_ERR]
                                   ##1 irq_out || !pend_r[`SICC_PEND_ERR])
        else $error("error event lost");
    // status bit 15 carries the counter, so only control reads are held to zero there
    AST_RSVD: assert property (s_axi_arvalid_in && s_axi_arready_out
                               && reg_sel(s_axi_araddr_in) == 2'h1
                               |=> !s_axi_rdata_out[`SICC_RSVD_BIT])
        else $error("reserved bit read as one");
    AST_THR_ZERO: assert property (ctrl_byte_write(2) && new_thr == 8'h00
                                   |=> $stable(ctrl_r.threshold))
        else $error("zero threshold write took effect");
    AST_THR_WRITE: assert property (ctrl_byte_write(2) && new_thr != 8'h00
                                    |=> ctrl_r.threshold == $past(new_thr))
        else $error("threshold write lost");
    AST_RST_VAL: assert property (@(posedge clk_in) disable iff (1'b0) srst_in
                                  |=> ctrl_r.threshold == `SICC_THR_RST
                                  && ctrl_r.timeout == `SICC_TMO_RST && !irq_out)
        else $error("control register reset value wrong");
    AST_SG_OFF: assert property (!SG_PRESENT |-> !pend_r[`SICC_PEND_DLY])
        else $error("delay interrupt without scatter-gather");
    AST_BRESP: assert property (do_write |=> s_axi_bvalid_out)
        else $error("write response missing");
endmodule

// [sicc_defines.svh]
// offsets, field positions, reset values and timing counts of the coalescing block
`ifndef SICC_DEFINES_SVH
`define SICC_DEFINES_SVH

`define SICC_CTRL_OFS 8'h00
`define SICC_STAT_OFS 8'h04

`define SICC_CMP_EN_BIT 12
`define SICC_DLY_EN_BIT 13
`define SICC_ERR_EN_BIT 14
`define SICC_RSVD_BIT 15
`define SICC_THR_LSB 16
`define SICC_THR_MSB 23
`define SICC_TMO_LSB 24
`define SICC_TMO_MSB 31

`define SICC_THR_RST 8'h01
`define SICC_TMO_RST 8'h00

`define SICC_PEND_CMP 0
`define SICC_PEND_DLY 1
`define SICC_PEND_ERR 2
`define SICC_STAT_CNT_LSB 8
`define SICC_STAT_RUN_BIT 16

`define SICC_RESP_OKAY 2'h0
`define SICC_RESP_SLVERR 2'h2

`define SICC_CLK_PERIOD_NS 100
`define SICC_DLY_UNIT_PERIODS 125
`define SICC_DLY_UNIT_CYC (`SICC_DLY_UNIT_PERIODS * `SICC_CLK_PERIOD_NS / `SICC_CLK_PERIOD_NS)

`endif

// [sicc_pkg.sv]
// types shared by the coalescing block
package sicc_pkg;

    typedef struct packed {
        logic [7:0] timeout;
        logic [7:0] threshold;
        logic err_en;
        logic dly_en;
        logic cmp_en;
    } sicc_ctrl_s;

    typedef enum logic [0:0] {
        SICC_IDLE = 1'b0,
        SICC_RESP = 1'b1
    } sicc_bus_e;

endpackage

// [sicc_delay_timer.sv]
// packet gap timer counting in units of the scatter-gather clock
`timescale 1ns/1ns
`include "sicc_defines.svh"

module sicc_delay_timer #(
    parameter int UNIT_CYC = `SICC_DLY_UNIT_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // control
    input wire logic [7:0] timeout_in,
    // packet events
    input wire logic packet_start_in,
    input wire logic packet_end_in,
    // results
    output logic expire_out,
    output logic running_out
);

    localparam int CW = 8 + $clog2(UNIT_CYC + 1);

    logic [CW-1:0] cnt_r, cnt_nxt, target;
    logic run_r, run_nxt, exp_r, exp_nxt;

    always_comb begin
        target = CW'(timeout_in * UNIT_CYC);
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        exp_nxt = 1'b0;
        if (packet_end_in) begin
            run_nxt = 1'b1;
            cnt_nxt = '0;
        end else if (packet_start_in) begin
            run_nxt = 1'b0;
            cnt_nxt = '0;
        end else if (run_r && timeout_in != 8'h00) begin
            if (cnt_r >= target - CW'(1)) begin
                exp_nxt = 1'b1;
                run_nxt = 1'b0;
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expire_out = exp_r;
    assign running_out = run_r;

    // helper: cycles since the last packet end, and whether the timeout moved meanwhile
    logic [CW:0] elapsed_r;
    logic tmo_chg_r;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            elapsed_r <= '0;
            tmo_chg_r <= 1'b0;
        end else begin
            elapsed_r <= packet_end_in ? (CW+1)'(1) : elapsed_r + (CW+1)'(1);
            tmo_chg_r <= packet_end_in ? 1'b0 : (tmo_chg_r || !$stable(timeout_in));
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    AST_TMR_ZERO: assert property (timeout_in == 8'h00 |=> !expire_out)
        else $error("delay timer expired with zero timeout");
    AST_TMR_RESTART: assert property (packet_start_in && !packet_end_in |=> !running_out)
        else $error("timer still running after packet start");
    AST_TMR_PERIOD: assert property (expire_out && !tmo_chg_r |-> elapsed_r == (CW+1)'(target) + (CW+1)'(1))
        else $error("delay expiry not at timeout times unit");
endmodule

// [sicc_host_model.sv]
// host-side model that watches the interrupt line and counts its requests
`timescale 1ns/1ns

module sicc_host_model (
    // clock
    input wire logic clk_in,
    // interrupt from the block
    input wire logic irq_in,
    // requests seen
    output int rises_out
);
    logic last_r = 1'b0;
    int count_r = 0;
    // a level line: only a rising edge is a new request, a held one counts once
    always @(posedge clk_in) begin
        if (irq_in && !last_r) begin
            count_r <= count_r + 1;
        end
        last_r <= irq_in;
    end
    assign rises_out = count_r;
endmodule

// [sicc_tb.sv]
// self-checking bench for the interrupt coalescing block
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end

module testbench;
    localparam int UNIT = 4;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] ev = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int bad_count = 0;
    int n_checks = 0;
    int rises;

    sicc_irq_coalesce #(.DLY_UNIT_CYC(UNIT)) u_sicc_irq_coalesce (
        .clk_in(clk_in), .srst_in(srst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .completion_event_in(ev[0]), .error_event_in(ev[1]),
        .packet_start_in(ev[2]), .packet_end_in(ev[3]), .irq_out(irq));

    sicc_host_model u_sicc_host_model (.clk_in(clk_in), .irq_in(irq), .rises_out(rises));

    initial begin
        forever #50 clk_in = ~clk_in;
    end

    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ready is a flop output, so the level at the falling edge is the one the next edge sees
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                      input logic [3:0] s = 4'hF);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk_in);
            ta = ta | (awvalid & awready);
            tw = tw | (wvalid & wready);
            @(posedge clk_in);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        do @(negedge clk_in); while (bvalid !== 1'b1);
        `CHK("write response", er, bresp)
        // bready stays up, so a following call never lowers and raises it in one step
        @(posedge clk_in);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk_in); while (arready !== 1'b1);
        @(posedge clk_in);
        arvalid <= 1'b0;
        do @(negedge clk_in); while (rvalid !== 1'b1);
        `CHK("read data", ed, rdata)
        `CHK("read response", er, rresp)
        @(posedge clk_in);
    endtask

    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge clk_in);
        ev <= 4'h0;
    endtask

    task automatic see_irq(input logic e, input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
        `CHK("irq", e, irq)
        @(posedge clk_in);
    endtask

    task automatic t_reset();
        rc(8'h00, 32'h0001_0000, 2'h0);
    endtask

    task automatic t_fields();
        wr(8'h00, 32'hFFFF_FFFF, 2'h0);
        rc(8'h00, 32'hFFFF_7000, 2'h0);
        wr(8'h00, 32'h0000_7000, 2'h0);
        rc(8'h00, 32'h00FF_7000, 2'h0);
        wr(8'h08, 32'hFFFF_FFFF, 2'h2);
        rc(8'h08, 32'h0000_0000, 2'h2);
        rc(8'h00, 32'h00FF_7000, 2'h0);
        wr(8'h00, 32'h0500_0000, 2'h0, 4'h8);
        rc(8'h00, 32'h05FF_7000, 2'h0);
    endtask

    task automatic t_coalesce();
        int r0;
        wr(8'h00, 32'h0002_1000, 2'h0);
        wr(8'h04, 32'h0000_0007, 2'h0);
        r0 = rises;
        pulse(0);
        see_irq(1'b0, 2);
        rc(8'h04, 32'h0000_0100, 2'h0);
        pulse(0);
        see_irq(1'b1, 2);
        rc(8'h04, 32'h0000_0201, 2'h0);
        wr(8'h04, 32'h0000_0007, 2'h0);
        see_irq(1'b0, 1);
        pulse(0);
        see_irq(1'b0, 2);
        pulse(0);
        see_irq(1'b1, 2);
        `CHK("interrupt count", r0 + 2, rises)
        wr(8'h04, 32'h0000_0007, 2'h0);
    endtask

    task automatic t_enables();
        wr(8'h00, 32'h0001_0000, 2'h0);
        pulse(0);
        see_irq(1'b0, 2);
        pulse(1);
        see_irq(1'b0, 2);
        wr(8'h00, 32'h0001_4000, 2'h0);
        pulse(1);
        see_irq(1'b1, 2);
        wr(8'h04, 32'h0000_0007, 2'h0);
        see_irq(1'b0, 1);
    endtask

    // the timer unit is shortened to UNIT cycles so a timeout of 3 stays short
    task automatic t_delay();
        wr(8'h00, 32'h0301_2000, 2'h0);
        pulse(3);
        see_irq(1'b0, 3 * UNIT);
        see_irq(1'b1, 0);
        wr(8'h04, 32'h0000_0007, 2'h0);
        pulse(3);
        see_irq(1'b0, 4);
        pulse(2);
        see_irq(1'b0, 20);
        wr(8'h00, 32'h0001_2000, 2'h0);
        pulse(3);
        see_irq(1'b0, 30);
    endtask

    // reset in mid-run with a pending interrupt and non-default fields
    task automatic t_midreset();
        wr(8'h00, 32'h0301_4000, 2'h0);
        pulse(1);
        see_irq(1'b1, 1);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        rc(8'h00, 32'h0001_0000, 2'h0);
        see_irq(1'b0, 0);
    endtask

    initial begin
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        t_reset();
        t_fields();
        t_coalesce();
        t_enables();
        t_delay();
        t_midreset();
        print_verdict();
    end

    // the whole sequence needs a few hundred cycles; a hung handshake stops here
    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        print_verdict();
    end
endmodule
